// File: logic/cmpc_map.vh
// Register map and field layout of the comparator control and status block.
// Assumes an 8-bit special-function bus with a page select and byte address.
`ifndef CMPC_MAP_VH
`define CMPC_MAP_VH

`define CMPC_PAGE 8'h02
`define CMPC_CTRL_ADDR 8'h88
`define CMPC_MODE_ADDR 8'h89
`define CMPC_CTRL_RESET 8'h00
`define CMPC_MODE_RESET 8'h02
`define CMPC_BIT_ON 7
`define CMPC_BIT_RESULT 6
`define CMPC_BIT_RISE 5
`define CMPC_BIT_FALL 4
`define CMPC_POS_HI 3
`define CMPC_POS_LO 2
`define CMPC_NEG_HI 1
`define CMPC_NEG_LO 0
`define CMPC_BIT_RISE_EN 5
`define CMPC_BIT_FALL_EN 4
`define CMPC_SPEED_HI 1
`define CMPC_SPEED_LO 0
`define CMPC_MODE_WMASK 8'h33
`define CMPC_SYNC_RESET 1'b0

`endif

// File: logic/cmpc_sync.v
// Two-stage synchroniser for the asynchronous comparator output.
// Assumes the input is a level that may change at any time.
`timescale 1ns/100ps
`include "cmpc_map.vh"
module cmpc_sync (
  // Clock and control
  input wire clk_in,
  input wire srst_in,
  input wire ce_in,
  // Level
  input wire async_in,
  output reg sync_out
);

  reg stage1;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second stage, to let metastability settle
  always @(posedge clk_in) begin
    if (srst_in) begin
      stage1 <= `CMPC_SYNC_RESET;
      sync_out <= `CMPC_SYNC_RESET;
    end else if (ce_in) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // cmpc_sync

// File: logic/cmpc_top.v
// Control and status logic around the second on-chip voltage comparator.
// Assumes a synchronous special-function bus: one-cycle write strobes and
// combinational read data selected by page and address.
//
// Contract
// - Enable bit 7 of control powers comparator; zero keeps it shut down.
// - Control bit 6 reads the synchronised comparator result, zero while disabled.
// - Control bit 5 sets on a rising edge of the comparator output.
// - Control bit 4 sets on a falling edge of the comparator output.
// - Control bits 3..2 select positive hysteresis; 00 disables it.
// - Control bits 1..0 select negative hysteresis; 00 disables it.
// - Reset loads control register with all zeros.
// - Rising-edge interrupt request only while mode bit 5 is set.
// - Falling-edge interrupt request only while mode bit 4 is set.
// - Mode bits 7..6 and 3..2 read zero and ignore writes.
// - Mode bits 1..0 select response time, 0 fastest, 3 lowest power.
// - Reset loads mode register with 0x02.
// - Edge flags stay set until software writes zero.
// - Disabled comparator drives its pin output low and raises no interrupt.
// - This comparator offers no reset-source path.
`timescale 1ns/100ps
`include "cmpc_map.vh"
module cmpc_top (
  // Clock, reset, enable
  input wire REF_CLK_IN,
  input wire SRST_IN,
  input wire CE_IN,
  // Special-function bus
  input wire [7:0] SFR_PAGE_IN,
  input wire [7:0] SFR_ADDR_IN,
  input wire SFR_WR_IN,
  input wire [7:0] SFR_WDATA_IN,
  output reg [7:0] SFR_RDATA_OUT,
  output reg SFR_HIT_OUT,
  // Analog comparator
  input wire COMPARATOR_RAW_IN,
  output wire COMPARATOR_ON_OUT,
  output wire [1:0] POS_HYST_SEL_OUT,
  output wire [1:0] NEG_HYST_SEL_OUT,
  output wire [1:0] RESPONSE_SPEED_SEL_OUT,
  // Pin routing and interrupt requests
  output wire COMPARATOR_PIN_OUT,
  output wire RISE_IRQ_OUT,
  output wire FALL_IRQ_OUT
);

  reg comparator_on;
  reg rise_edge_flag;
  reg fall_edge_flag;
  reg [1:0] pos_hyst_sel;
  reg [1:0] neg_hyst_sel;
  reg rise_irq_en;
  reg fall_irq_en;
  reg [1:0] response_speed_sel;
  reg result_prev;
  wire comparator_result;
  wire page_hit;
  wire wr_ctrl;
  wire wr_mode;
  wire rise_seen;
  wire fall_seen;
  wire [7:0] ctrl_view;
  wire [7:0] mode_view;
  wire [7:0] ctrl_reset;
  wire [7:0] mode_reset;

  // Reset images, so each field takes its own bits of the documented value
  assign ctrl_reset = `CMPC_CTRL_RESET;
  assign mode_reset = `CMPC_MODE_RESET;

  ////////////////////////////////////////////////////////////////////////
  // Synchroniser; the analog output is asynchronous to the system clock
  cmpc_sync u_sync (
    .clk_in(REF_CLK_IN),
    .srst_in(SRST_IN),
    .ce_in(CE_IN),
    .async_in(COMPARATOR_RAW_IN),
    .sync_out(comparator_result)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign page_hit = (SFR_PAGE_IN == `CMPC_PAGE);
  assign wr_ctrl = CE_IN & SFR_WR_IN & page_hit & (SFR_ADDR_IN == `CMPC_CTRL_ADDR);
  assign wr_mode = CE_IN & SFR_WR_IN & page_hit & (SFR_ADDR_IN == `CMPC_MODE_ADDR);

  // Edges only count while enabled, since a powered-down output is meaningless
  assign rise_seen = comparator_on & comparator_result & ~result_prev;
  assign fall_seen = comparator_on & ~comparator_result & result_prev;

  ////////////////////////////////////////////////////////////////////////
  // Previous synchronised result for edge detection
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      result_prev <= `CMPC_SYNC_RESET;
    end else if (CE_IN) begin
      result_prev <= comparator_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register; a hardware set wins over a same-cycle clear
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      comparator_on <= ctrl_reset[`CMPC_BIT_ON];
      rise_edge_flag <= ctrl_reset[`CMPC_BIT_RISE];
      fall_edge_flag <= ctrl_reset[`CMPC_BIT_FALL];
      pos_hyst_sel <= ctrl_reset[`CMPC_POS_HI:`CMPC_POS_LO];
      neg_hyst_sel <= ctrl_reset[`CMPC_NEG_HI:`CMPC_NEG_LO];
    end else if (CE_IN) begin
      if (wr_ctrl) begin
        comparator_on <= SFR_WDATA_IN[`CMPC_BIT_ON];
        pos_hyst_sel <= SFR_WDATA_IN[`CMPC_POS_HI:`CMPC_POS_LO];
        neg_hyst_sel <= SFR_WDATA_IN[`CMPC_NEG_HI:`CMPC_NEG_LO];
      end
      // Flags hold until written; a written one also sets, as a flop would
      if (rise_seen) begin
        rise_edge_flag <= 1'b1;
      end else if (wr_ctrl) begin
        rise_edge_flag <= SFR_WDATA_IN[`CMPC_BIT_RISE];
      end
      if (fall_seen) begin
        fall_edge_flag <= 1'b1;
      end else if (wr_ctrl) begin
        fall_edge_flag <= SFR_WDATA_IN[`CMPC_BIT_FALL];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode register; unused bits are never stored
  always @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      rise_irq_en <= mode_reset[`CMPC_BIT_RISE_EN];
      fall_irq_en <= mode_reset[`CMPC_BIT_FALL_EN];
      response_speed_sel <= mode_reset[`CMPC_SPEED_HI:`CMPC_SPEED_LO];
    end else if (CE_IN & wr_mode) begin
      rise_irq_en <= SFR_WDATA_IN[`CMPC_BIT_RISE_EN];
      fall_irq_en <= SFR_WDATA_IN[`CMPC_BIT_FALL_EN];
      response_speed_sel <= SFR_WDATA_IN[`CMPC_SPEED_HI:`CMPC_SPEED_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read views
  assign ctrl_view = {comparator_on, comparator_result & comparator_on,
                      rise_edge_flag, fall_edge_flag, pos_hyst_sel, neg_hyst_sel};
  assign mode_view = {2'h0, rise_irq_en, fall_irq_en, 2'h0, response_speed_sel}
                     & `CMPC_MODE_WMASK;

  // Combinational read mux with a hit flag; unmapped addresses read zero
  always @* begin
    SFR_RDATA_OUT = 8'h00;
    SFR_HIT_OUT = 1'b0;
    if (page_hit && SFR_ADDR_IN == `CMPC_CTRL_ADDR) begin
      SFR_RDATA_OUT = ctrl_view;
      SFR_HIT_OUT = 1'b1;
    end else if (page_hit && SFR_ADDR_IN == `CMPC_MODE_ADDR) begin
      SFR_RDATA_OUT = mode_view;
      SFR_HIT_OUT = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog controls; no reset-source output exists for this comparator
  assign COMPARATOR_ON_OUT = comparator_on;
  assign POS_HYST_SEL_OUT = pos_hyst_sel;
  assign NEG_HYST_SEL_OUT = neg_hyst_sel;
  assign RESPONSE_SPEED_SEL_OUT = response_speed_sel;

  // Interrupts are level requests from the sticky flags, gated by enable;
  // software must clear stale flags after power-up before enabling
  assign COMPARATOR_PIN_OUT = comparator_on & comparator_result;
  assign RISE_IRQ_OUT = comparator_on & rise_irq_en & rise_edge_flag;
  assign FALL_IRQ_OUT = comparator_on & fall_irq_en & fall_edge_flag;

endmodule // cmpc_top

// File: verif/cmpc_checker.sv
// Port assertions for the comparator control block.
// Assumes it is bound to cmpc_top: one clock, synchronous reset.
`timescale 1ns/100ps
module cmpc_checker (
  // Clock, reset and bus
  input wire REF_CLK_IN,
  input wire SRST_IN,
  input wire CE_IN,
  input wire [7:0] SFR_ADDR_IN,
  input wire SFR_WR_IN,
  input wire [7:0] SFR_WDATA_IN,
  input wire [7:0] SFR_RDATA_OUT,
  input wire SFR_HIT_OUT,
  // Comparator side
  input wire COMPARATOR_RAW_IN,
  input wire COMPARATOR_ON_OUT,
  input wire [1:0] POS_HYST_SEL_OUT,
  input wire [1:0] NEG_HYST_SEL_OUT,
  input wire [1:0] RESPONSE_SPEED_SEL_OUT,
  input wire COMPARATOR_PIN_OUT,
  input wire RISE_IRQ_OUT,
  input wire FALL_IRQ_OUT
);
  // Accepted writes and mode reads, judged by the block's own hit output
  wire take = SFR_HIT_OUT & SFR_WR_IN & CE_IN;
  wire wc = take & (SFR_ADDR_IN == 8'h88);
  wire wm = take & (SFR_ADDR_IN == 8'h89);
  wire rm = SFR_HIT_OUT & (SFR_ADDR_IN == 8'h89);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);
  ////////////////////////////////////////
  property p_rc; $fell(SRST_IN) |-> {COMPARATOR_ON_OUT, POS_HYST_SEL_OUT} == 3'h0; endproperty
  a_rc: assert property (p_rc) else $error("control reset");
  property p_rm; $fell(SRST_IN) |-> RESPONSE_SPEED_SEL_OUT == 2'h2; endproperty
  a_rm: assert property (p_rm) else $error("mode reset");
  property p_on; wc |=> COMPARATOR_ON_OUT == $past(SFR_WDATA_IN[7]); endproperty
  a_on: assert property (p_on) else $error("enable");
  property p_hy; wc |=> {POS_HYST_SEL_OUT, NEG_HYST_SEL_OUT} == $past(SFR_WDATA_IN[3:0]); endproperty
  a_hy: assert property (p_hy) else $error("hysteresis");
  property p_sp; wm |=> RESPONSE_SPEED_SEL_OUT == $past(SFR_WDATA_IN[1:0]); endproperty
  a_sp: assert property (p_sp) else $error("speed");
  property p_rs; rm |-> (SFR_RDATA_OUT & 8'hcc) == 8'h00; endproperty
  a_rs: assert property (p_rs) else $error("unused mode bits");
  property p_of; !COMPARATOR_ON_OUT |-> !COMPARATOR_PIN_OUT && !FALL_IRQ_OUT && !RISE_IRQ_OUT; endproperty
  a_of: assert property (p_of) else $error("output while off");
  property p_ri; rm && !SFR_RDATA_OUT[5] |-> !RISE_IRQ_OUT; endproperty
  a_ri: assert property (p_ri) else $error("rise request");
  // The pin can only rise two edges after the raw level was high
  property p_sy; $rose(COMPARATOR_PIN_OUT) |-> $past(COMPARATOR_RAW_IN, 2); endproperty
  a_sy: assert property (p_sy) else $error("synchroniser");
endmodule // cmpc_checker
bind cmpc_top cmpc_checker i_chk (.*);

// File: verif/comparator1_control_status_tb.sv
// Self-checking bench for the comparator control block with an inline model.
// Assumes cmpc_top, a 25 MHz clock and the bus answering on page 2.
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module comparator1_control_status_tb;
  reg clk = 0, srst = 1, ce = 1, wr = 0, raw = 0;
  reg [7:0] page = 8'h02, addr = 8'h88, wdata = 8'h00;
  wire [7:0] rdata;
  wire hit, on, pin, rirq, firq;
  wire [1:0] pos, neg, spd;
  integer n_errors = 0, comparisons = 0, ctrl = 0, mode = 2, rawv = 0, i, r;
  ////////////////////////////////////////
  cmpc_top i_dut (.REF_CLK_IN(clk), .SRST_IN(srst), .CE_IN(ce), .SFR_PAGE_IN(page),
    .SFR_ADDR_IN(addr), .SFR_WR_IN(wr), .SFR_WDATA_IN(wdata), .SFR_RDATA_OUT(rdata),
    .SFR_HIT_OUT(hit), .COMPARATOR_RAW_IN(raw), .COMPARATOR_ON_OUT(on),
    .POS_HYST_SEL_OUT(pos), .NEG_HYST_SEL_OUT(neg), .RESPONSE_SPEED_SEL_OUT(spd),
    .COMPARATOR_PIN_OUT(pin), .RISE_IRQ_OUT(rirq), .FALL_IRQ_OUT(firq));
  // 40 ns system clock
  initial begin
    forever #20 clk = ~clk;
  end
  // One write, then an idle edge so the strobe is never raised twice in a step
  task wreg(input [7:0] p, input [7:0] a, input [7:0] d);
    begin
      page = p; addr = a; wdata = d; wr = 1;
      @(posedge clk); #1 wr = 0;
      if (p == 8'h02 && ce && a == 8'h88) ctrl = d & 8'hbf;
      if (p == 8'h02 && ce && a == 8'h89) mode = d & 8'h33;
      page = 8'h02;
      @(posedge clk); #1;
    end
  endtask
  // Raw level change; four edges cover the two-flop delay plus detection
  task setraw(input integer v);
    begin
      if (ctrl[7] && v != rawv) ctrl = ctrl | (v ? 8'h20 : 8'h10);
      rawv = v; raw = v;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  // Model against reads and outputs; result bit reads 0 while off
  task chk;
    begin
      r = ctrl | (((ctrl >> 7) & rawv) << 6);
      addr = 8'h88;
      #2 `CHK({hit, rdata}, {1'b1, r[7:0]})
      @(posedge clk); #1 addr = 8'h89;
      #2 `CHK({hit, rdata}, {1'b1, mode[7:0]})
      `CHK({on, pos, neg, spd}, {r[7], r[3:0], mode[1:0]})
      `CHK({pin, rirq, firq}, {r[6], r[7] & mode[5] & r[5], r[7] & mode[4] & r[4]})
      @(posedge clk); #1 addr = 8'h8a;
      #2 `CHK({hit, rdata}, 9'h000)
      @(posedge clk); #1;
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  // Main sequence; enable only changes while the raw level is low
  initial begin
    r = $urandom(6);
    repeat (16) @(posedge clk);
    #1 srst = 0;
    chk;
    setraw(1);
    setraw(0);
    chk;
    wreg(8'h02, 8'h88, 8'h80);
    wreg(8'h02, 8'h88, 8'h80);
    for (i = 0; i < 40; i++) begin
      r = $urandom;
      wreg(8'h02, 8'h89, r[7:0]);
      r = $urandom;
      wreg(8'h02, 8'h88, rawv ? (8'h80 | r[7:0]) : r[7:0]);
      if (ctrl[7]) setraw($urandom % 2);
      chk;
    end
    if (ctrl[7]) setraw(0);
    ce = 0;
    wreg(8'h02, 8'h88, 8'h3f);
    ce = 1;
    wreg(8'h01, 8'h88, 8'h3f);
    chk;
    wreg(8'h02, 8'h89, 8'h30);
    wreg(8'h02, 8'h88, 8'h30);
    chk;
    srst = 1;
    repeat (2) @(posedge clk);
    #1 srst = 0;
    ctrl = 0;
    mode = 2;
    chk;
    print_verdict;
  end
  // Hang guard; the sequence needs well under 100 us
  initial begin
    #200000;
    n_errors++;
    print_verdict;
  end
endmodule // comparator1_control_status_tb
